// File: core/arith_logic_datapath.sv
/*
  Eight-bit arithmetic and logic datapath with word add and subtract on a
  register pair, the status flags, and the single-bit i/o access path.
  Assumes the decoder holds operands stable while op_valid and op_ready,
  and writes results back when res_valid pulses.
*/
`default_nettype none
module arith_logic_datapath
  import alu_pkg::*;
#(
  parameter int WORD_K_W = WORD_IMM_W
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [DATA_W-1:0] rd_val,
  input wire logic [DATA_W-1:0] rdh_val,
  input wire logic [DATA_W-1:0] rr_val,
  input wire logic [DATA_W-1:0] imm,
  output logic op_ready,
  output logic res_valid,
  output logic res_pair,
  output logic [DATA_W-1:0] res_lo,
  output logic [DATA_W-1:0] res_hi,
  output logic [FLAG_W-1:0] flags,
  output logic bad_op,
  input wire logic io_valid,
  input wire logic [1:0] io_cmd,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic [BIT_SEL_W-1:0] io_bit,
  input wire logic [DATA_W-1:0] io_rdata,
  output logic io_wr,
  output logic [DATA_W-1:0] io_wmask,
  output logic [DATA_W-1:0] io_wdata,
  output logic io_skip,
  output logic io_err
);

  // refuse word constant widths the pair path cannot carry
  if (WORD_K_W < 1 || WORD_K_W > DATA_W) begin : g_bad_word_k_w
    $error("word constant width must be 1 to 8 bits");
  end

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_word_hi = 1'b1
  } dp_state_t;

  dp_state_t state_r;
  dp_state_t state_nxt;
  logic [FLAG_W-1:0] flags_r;
  logic [FLAG_W-1:0] flags_nxt;
  logic [DATA_W-1:0] res_lo_r;
  logic [DATA_W-1:0] res_lo_nxt;
  logic [DATA_W-1:0] res_hi_r;
  logic [DATA_W-1:0] res_hi_nxt;
  logic res_valid_r;
  logic res_valid_nxt;
  logic res_pair_r;
  logic res_pair_nxt;
  logic bad_op_r;
  logic bad_op_nxt;
  logic [DATA_W-1:0] wlo_r;
  logic [DATA_W-1:0] whi_r;
  logic wcy_r;
  logic wsub_r;
  logic take;
  logic [DATA_W-1:0] kword;
  logic [9:0] lo_add;
  logic [9:0] lo_sub;
  logic [9:0] hi_res;

  // add a, b and carry in; returns half carry, carry, sum
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic ci);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    return {lo[4], s};
  endfunction

  // subtract b and borrow in from a; returns half borrow, borrow, diff
  function automatic logic [9:0] sub8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic ci);
    logic [4:0] lo;
    logic [8:0] s;
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    return {lo[4], s};
  endfunction

  // byte arithmetic flags: Z C N V H, S left as it was
  function automatic logic [5:0] arith_flags(input logic [5:0] f,
                                             input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic [9:0] r,
                                             input logic sub);
    logic [5:0] o;
    o = f;
    o[FLAG_Z] = (r[7:0] == ALL_ZERO);
    o[FLAG_C] = r[8];
    o[FLAG_N] = r[7];
    o[FLAG_V] = sub ? ((a[7] != b[7]) && (r[7] != a[7]))
                    : ((a[7] == b[7]) && (r[7] != a[7]));
    o[FLAG_H] = r[9];
    return o;
  endfunction

  // logic flags: Z N, V cleared, the rest untouched
  function automatic logic [5:0] logic_flags(input logic [5:0] f,
                                             input logic [7:0] r);
    logic [5:0] o;
    o = f;
    o[FLAG_Z] = (r == ALL_ZERO);
    o[FLAG_N] = r[7];
    o[FLAG_V] = 1'b0;
    return o;
  endfunction

  // word flags from the old high byte and the 16-bit result
  function automatic logic [5:0] word_flags(input logic [5:0] f,
                                            input logic [7:0] oh,
                                            input logic [15:0] r,
                                            input logic sub);
    logic [5:0] o;
    o = f;
    o[FLAG_Z] = (r == 16'h0000);
    o[FLAG_N] = r[15];
    o[FLAG_V] = sub ? (oh[7] && !r[15]) : (!oh[7] && r[15]);
    o[FLAG_C] = sub ? (r[15] && !oh[7]) : (oh[7] && !r[15]);
    o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
    return o;
  endfunction

  // handshake and shared arithmetic terms
  assign op_ready = (state_r == st_idle);
  assign take = op_valid && op_ready;
  assign kword = DATA_W'(imm[WORD_K_W-1:0]);
  assign lo_add = add8(rd_val, kword, 1'b0);
  assign lo_sub = sub8(rd_val, kword, 1'b0);
  assign hi_res = wsub_r ? sub8(whi_r, ALL_ZERO, wcy_r)
                         : add8(whi_r, ALL_ZERO, wcy_r);

  // operation decode; every branch starts from the held flags
  always_comb begin
    logic [9:0] r;
    logic [7:0] lv;
    r = 10'h000;
    lv = ALL_ZERO;
    state_nxt = state_r;
    flags_nxt = flags_r; // unnamed flags hold
    res_lo_nxt = res_lo_r;
    res_hi_nxt = res_hi_r;
    res_valid_nxt = 1'b0;
    res_pair_nxt = res_pair_r;
    bad_op_nxt = 1'b0;
    if (state_r == st_word_hi) begin
      // second clock of a word operation
      flags_nxt = word_flags(flags_r, whi_r, {hi_res[7:0], wlo_r}, wsub_r);
      res_lo_nxt = wlo_r;
      res_hi_nxt = hi_res[7:0];
      res_valid_nxt = 1'b1;
      res_pair_nxt = 1'b1;
      state_nxt = st_idle;
    end else if (take) begin
      res_valid_nxt = 1'b1;
      res_pair_nxt = 1'b0;
      res_hi_nxt = rdh_val;
      unique case (op_code)
        op_add, op_add_carry: begin
          r = add8(rd_val, rr_val, (op_code == op_add_carry) &&
                   flags_r[FLAG_C]);
          flags_nxt = arith_flags(flags_r, rd_val, rr_val, r, 1'b0);
          res_lo_nxt = r[7:0];
        end
        op_sub, op_subtract_constant: begin
          lv = (op_code == op_sub) ? rr_val : imm;
          r = sub8(rd_val, lv, 1'b0);
          flags_nxt = arith_flags(flags_r, rd_val, lv, r, 1'b1);
          res_lo_nxt = r[7:0];
        end
        op_subtract_with_borrow, op_subtract_constant_with_borrow: begin
          lv = (op_code == op_subtract_with_borrow) ? rr_val : imm;
          r = sub8(rd_val, lv, flags_r[FLAG_C]);
          flags_nxt = arith_flags(flags_r, rd_val, lv, r, 1'b1);
          res_lo_nxt = r[7:0];
        end
        op_word_add_immediate, op_word_subtract_immediate: begin
          res_valid_nxt = 1'b0; // result follows on the second clock
          state_nxt = st_word_hi;
        end
        op_and, op_bitwise_and_with_constant: begin
          lv = rd_val & ((op_code == op_and) ? rr_val : imm);
          flags_nxt = logic_flags(flags_r, lv);
          res_lo_nxt = lv;
        end
        op_or, op_bitwise_or_with_constant, op_exclusive_or: begin
          if (op_code == op_exclusive_or)
            lv = rd_val ^ rr_val;
          else
            lv = rd_val | ((op_code == op_or) ? rr_val : imm);
          flags_nxt = logic_flags(flags_r, lv);
          res_lo_nxt = lv;
        end
        op_bitwise_invert: begin
          lv = ALL_ONES - rd_val;
          flags_nxt = logic_flags(flags_r, lv);
          flags_nxt[FLAG_C] = 1'b1;
          res_lo_nxt = lv;
        end
        op_arithmetic_minus: begin
          r = sub8(ALL_ZERO, rd_val, 1'b0);
          flags_nxt = arith_flags(flags_r, ALL_ZERO, rd_val, r, 1'b1);
          res_lo_nxt = r[7:0];
        end
        op_set_bits_by_mask: begin
          lv = rd_val | imm;
          flags_nxt = logic_flags(flags_r, lv);
          res_lo_nxt = lv;
        end
        op_clear_bits_by_mask: begin
          lv = rd_val & (ALL_ONES - imm);
          flags_nxt = logic_flags(flags_r, lv);
          res_lo_nxt = lv;
        end
        default: begin
          // unknown code: no result, no flag change
          res_valid_nxt = 1'b0;
          bad_op_nxt = 1'b1;
        end
      endcase
    end
  end

  // sequencing state
  always_ff @(posedge sys_clk) begin
    if (srst)
      state_r <= st_idle;
    else
      state_r <= state_nxt;
  end

  // status flags and result registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags_r <= FLAGS_RST;
      res_lo_r <= DATA_RST;
      res_hi_r <= DATA_RST;
      res_valid_r <= 1'b0;
      res_pair_r <= 1'b0;
      bad_op_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      res_lo_r <= res_lo_nxt;
      res_hi_r <= res_hi_nxt;
      res_valid_r <= res_valid_nxt;
      res_pair_r <= res_pair_nxt;
      bad_op_r <= bad_op_nxt;
    end
  end

  // first clock of a word operation: low byte and its carry
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wlo_r <= DATA_RST;
      whi_r <= DATA_RST;
      wcy_r <= 1'b0;
      wsub_r <= 1'b0;
    end else if (take && (op_code == op_word_add_immediate ||
                          op_code == op_word_subtract_immediate)) begin
      wsub_r <= (op_code == op_word_subtract_immediate);
      wlo_r <= (op_code == op_word_subtract_immediate) ? lo_sub[7:0]
                                                       : lo_add[7:0];
      wcy_r <= (op_code == op_word_subtract_immediate) ? lo_sub[8]
                                                       : lo_add[8];
      whi_r <= rdh_val;
    end
  end

  assign res_valid = res_valid_r;
  assign res_pair = res_pair_r;
  assign res_lo = res_lo_r;
  assign res_hi = res_hi_r;
  assign flags = flags_r;
  assign bad_op = bad_op_r;

  // single-bit i/o path
  io_bit_if io_bus ();

  assign io_bus.valid = io_valid;
  assign io_bus.cmd = io_cmd_t'(io_cmd);
  assign io_bus.addr = io_addr;
  assign io_bus.bit_sel = io_bit;
  assign io_bus.rdata = io_rdata;
  assign io_wr = io_bus.wr;
  assign io_wmask = io_bus.wmask;
  assign io_wdata = io_bus.wdata;
  assign io_skip = io_bus.skip;
  assign io_err = io_bus.err;

  io_bit_unit u_io_bit (
    .sys_clk(sys_clk),
    .srst(srst),
    .io(io_bus.unit)
  );

endmodule
`default_nettype wire

// File: inc/alu_pkg.sv
/*
  Shared constants and types of the eight-bit arithmetic and logic datapath:
  operation codes, flag positions, widths and the bit-access range.
  Assumes the decoder drives the operation codes listed here.
*/
`default_nettype none
package alu_pkg;

  // data widths
  localparam int DATA_W = 8;
  localparam int WORD_IMM_W = 6;
  localparam int FLAG_W = 6;
  localparam int IO_ADDR_W = 6;
  localparam int BIT_SEL_W = 3;

  // flag positions inside the status vector
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // reset values
  localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // constants used by the operations
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hFF;
  localparam logic [DATA_W-1:0] ALL_ZERO = 8'h00;

  // bit-accessible window of the i/o space
  localparam logic [IO_ADDR_W-1:0] IO_BIT_BOTTOM = 6'h00;
  localparam logic [IO_ADDR_W-1:0] IO_BIT_TOP = 6'h1F;

  // operation codes
  typedef enum logic [4:0] {
    op_add = 5'h00,
    op_add_carry = 5'h01,
    op_word_add_immediate = 5'h02,
    op_sub = 5'h03,
    op_subtract_constant = 5'h04,
    op_subtract_with_borrow = 5'h05,
    op_subtract_constant_with_borrow = 5'h06,
    op_word_subtract_immediate = 5'h07,
    op_and = 5'h08,
    op_bitwise_and_with_constant = 5'h09,
    op_or = 5'h0A,
    op_bitwise_or_with_constant = 5'h0B,
    op_exclusive_or = 5'h0C,
    op_bitwise_invert = 5'h0D,
    op_arithmetic_minus = 5'h0E,
    op_set_bits_by_mask = 5'h0F,
    op_clear_bits_by_mask = 5'h10
  } alu_op_t;

  // single-bit i/o commands
  typedef enum logic [1:0] {
    io_bit_set = 2'h0,
    io_bit_clear = 2'h1,
    skip_if_io_bit_one = 2'h2,
    skip_if_io_bit_zero = 2'h3
  } io_cmd_t;

endpackage
`default_nettype wire

// File: inc/io_bit_if.sv
/*
  Carrier between the datapath and its single-bit i/o unit.
  Assumes both ends share sys_clk.
*/
`default_nettype none
interface io_bit_if;
  import alu_pkg::*;
  logic valid;
  io_cmd_t cmd;
  logic [IO_ADDR_W-1:0] addr;
  logic [BIT_SEL_W-1:0] bit_sel;
  logic [DATA_W-1:0] rdata;
  logic wr;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] wdata;
  logic skip;
  logic err;

  modport ctl (output valid, cmd, addr, bit_sel, rdata,
               input wr, wmask, wdata, skip, err);
  modport unit (input valid, cmd, addr, bit_sel, rdata,
                output wr, wmask, wdata, skip, err);
endinterface
`default_nettype wire

// File: core/io_bit_unit.sv
/*
  Single-bit set, clear and bit-test on the low i/o register window.
  Assumes the i/o register owner applies wdata only under wmask and
  presents the addressed register on rdata in the request cycle.
*/
`default_nettype none
module io_bit_unit
  import alu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  io_bit_if.unit io
);

  logic in_range;
  logic [DATA_W-1:0] onehot;

  // window check and one-hot of the addressed bit
  assign in_range = (io.addr >= IO_BIT_BOTTOM) && (io.addr <= IO_BIT_TOP);
  assign onehot = 8'h01 << io.bit_sel;

  // register the write strobe, mask and data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      io.wr <= 1'b0;
      io.wmask <= DATA_RST;
      io.wdata <= DATA_RST;
    end else begin
      io.wr <= 1'b0;
      if (io.valid && in_range &&
          (io.cmd == io_bit_set || io.cmd == io_bit_clear)) begin
        io.wr <= 1'b1;
        io.wmask <= onehot; // only the addressed bit is written
        // other bits carry zero so no write-one-to-clear flag is hit
        io.wdata <= (io.cmd == io_bit_set) ? onehot : DATA_RST;
      end
    end
  end

  // register the skip decision and the range error
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      io.skip <= 1'b0;
      io.err <= 1'b0;
    end else begin
      io.err <= io.valid && !in_range; // outside window: nothing happens
      io.skip <= 1'b0;
      if (io.valid && in_range) begin
        unique case (io.cmd)
          skip_if_io_bit_one: io.skip <= io.rdata[io.bit_sel];
          skip_if_io_bit_zero: io.skip <= !io.rdata[io.bit_sel];
          io_bit_set, io_bit_clear: io.skip <= 1'b0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: test/alu_props.sv
/*
  Checker of the datapath's port timing and results.
  Assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
module alu_props
  import alu_pkg::*;
#(
  parameter int WORD_K_W = WORD_IMM_W
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [DATA_W-1:0] rd_val,
  input wire logic [DATA_W-1:0] imm,
  input wire logic [DATA_W-1:0] rr_val,
  input wire logic op_ready,
  input wire logic res_valid,
  input wire logic res_pair,
  input wire logic [DATA_W-1:0] res_lo,
  input wire logic [FLAG_W-1:0] flags,
  input wire logic io_valid,
  input wire logic [1:0] io_cmd,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic [BIT_SEL_W-1:0] io_bit,
  input wire logic [DATA_W-1:0] io_rdata,
  input wire logic io_wr,
  input wire logic [DATA_W-1:0] io_wmask,
  input wire logic io_skip,
  input wire logic io_err
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic take;
  logic word;
  logic skip_now;
  // request accepted, word codes, expected skip
  assign take = op_valid && op_ready;
  assign word = op_code == op_word_add_immediate
    || op_code == op_word_subtract_immediate;
  assign skip_now = io_rdata[io_bit] ^ io_cmd[0];
  sequence word_wait;
    !op_ready && !res_valid;
  endsequence
  sequence word_done;
    res_valid && res_pair && op_ready;
  endsequence
  word_two_clk_a: assert property (
    take && word |=> word_wait ##1 word_done)
    else $error("word op not done in two clocks");
  byte_one_clk_a: assert property (
    take && !word && op_code <= op_clear_bits_by_mask |=> res_valid && !res_pair)
    else $error("byte op not done in one clock");
  add_sum_a: assert property (
    take && op_code == op_add |=> res_lo == $past(rd_val) + $past(rr_val))
    else $error("add result wrong");
  and_flags_a: assert property (
    take && op_code == op_and |=> !flags[FLAG_V] && $stable(flags[FLAG_C])
      && $stable(flags[FLAG_S]) && $stable(flags[FLAG_H]))
    else $error("and touched flags it must keep");
  invert_res_a: assert property (
    take && op_code == op_bitwise_invert
      |=> res_lo == ~$past(rd_val) && flags[FLAG_C])
    else $error("invert result or carry wrong");
  clear_mask_a: assert property (
    take && op_code == op_clear_bits_by_mask
      |=> res_lo == ($past(rd_val) & ~$past(imm)))
    else $error("clear bits result wrong");
  io_range_a: assert property (
    io_valid && io_addr > IO_BIT_TOP |=> io_err && !io_wr && !io_skip)
    else $error("out of range bit access acted");
  io_onehot_a: assert property (
    io_valid && io_cmd <= 2'h1 && io_addr <= IO_BIT_TOP
      |=> io_wr && io_wmask == 8'h01 << $past(io_bit))
    else $error("bit write mask wrong");
  io_skip_a: assert property (
    io_valid && io_cmd[1] && io_addr <= IO_BIT_TOP
      |=> io_skip == $past(skip_now))
    else $error("skip decision wrong");
endmodule
bind arith_logic_datapath alu_props #(.WORD_K_W(WORD_K_W)) i_alu_props (
  .sys_clk(sys_clk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
  .rd_val(rd_val), .imm(imm), .rr_val(rr_val), .op_ready(op_ready),
  .res_valid(res_valid), .res_pair(res_pair), .res_lo(res_lo),
  .flags(flags), .io_valid(io_valid), .io_cmd(io_cmd), .io_addr(io_addr),
  .io_bit(io_bit), .io_rdata(io_rdata), .io_wr(io_wr),
  .io_wmask(io_wmask), .io_skip(io_skip), .io_err(io_err));
`default_nettype wire

// File: test/io_reg_model.sv
/*
  Model of the low i/o register window that owns the bit-accessible
  registers. Assumes writes arrive one cycle after the request.
*/
`default_nettype none
module io_reg_model
  import alu_pkg::*;
#(
  parameter logic [DATA_W-1:0] CLR_ON_ONE = 8'h80,
  parameter logic [DATA_W-1:0] INIT_VAL = 8'hA5
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic io_valid,
  input wire logic [IO_ADDR_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic [DATA_W-1:0] io_wmask,
  input wire logic [DATA_W-1:0] io_wdata,
  output logic [DATA_W-1:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] regs [32];
  logic [4:0] wsel_r;
  // addressed register shown in the request cycle, junk outside the window
  assign io_rdata = io_addr[5] ? 8'h5A : regs[io_addr[4:0]];
  // remember where the following write lands
  always_ff @(posedge sys_clk) begin
    if (io_valid) begin
      wsel_r <= io_addr[4:0];
    end
  end
  // writes act only under the mask; some flags clear on a one
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < 32; i++) begin
        regs[i] <= INIT_VAL;
      end
    end else if (io_wr) begin
      regs[wsel_r] <= (regs[wsel_r] & ~io_wmask)
        | (io_wmask & ~CLR_ON_ONE & io_wdata)
        | (io_wmask & CLR_ON_ONE & regs[wsel_r] & ~io_wdata);
    end
  end
endmodule
`default_nettype wire

// File: test/arith_logic_datapath_tb_top.sv
/*
  Self-checking bench of the datapath with its i/o register partner.
  Assumes the bit-write partner model and the bound checker.
*/
`default_nettype none
`define CHK(got, exp, msg) \
  begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module arith_logic_datapath_tb_top
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, srst, op_valid, op_ready, res_valid, res_pair, bad_op;
  logic [4:0] op_code;
  logic [7:0] rd_val, rdh_val, rr_val, imm, res_lo, res_hi;
  logic [5:0] flags, exp_f;
  logic io_valid, io_wr, io_skip, io_err;
  logic [1:0] io_cmd;
  logic [5:0] io_addr;
  logic [2:0] io_bit;
  logic [7:0] io_rdata, io_wmask, io_wdata;
  int n_mismatch, samples_checked, cyc;
  arith_logic_datapath i_arith_logic_datapath (.sys_clk(sys_clk),
    .srst(srst), .op_valid(op_valid), .op_code(op_code), .rd_val(rd_val),
    .rdh_val(rdh_val), .rr_val(rr_val), .imm(imm), .op_ready(op_ready),
    .res_valid(res_valid), .res_pair(res_pair), .res_lo(res_lo),
    .res_hi(res_hi), .flags(flags), .bad_op(bad_op), .io_valid(io_valid),
    .io_cmd(io_cmd), .io_addr(io_addr), .io_bit(io_bit),
    .io_rdata(io_rdata), .io_wr(io_wr), .io_wmask(io_wmask),
    .io_wdata(io_wdata), .io_skip(io_skip), .io_err(io_err));
  io_reg_model i_io_reg_model (.sys_clk(sys_clk), .srst(srst),
    .io_valid(io_valid), .io_addr(io_addr), .io_wr(io_wr),
    .io_wmask(io_wmask), .io_wdata(io_wdata), .io_rdata(io_rdata));
  // expected result and flags: {hi, lo, flags}
  function automatic logic [21:0] calc(input alu_op_t op,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] h,
      input logic [5:0] f);
    logic [8:0] s;
    logic [4:0] n;
    logic [15:0] w;
    logic c;
    logic [7:0] r;
    logic ad;
    c = f[FLAG_C] & (op == op_add_carry || op == op_subtract_with_borrow
      || op == op_subtract_constant_with_borrow);
    ad = op == op_word_add_immediate;
    f[FLAG_V] = 1'b0;
    case (op)
      op_add, op_add_carry: begin
        s = a + b + c;
        n = a[3:0] + b[3:0] + c;
        r = s[7:0];
        f[FLAG_C] = s[8];
        f[FLAG_H] = n[4];
        f[FLAG_V] = a[7] == b[7] && r[7] != a[7];
      end
      op_word_add_immediate, op_word_subtract_immediate: begin
        w = ad ? {h, a} + b[5:0] : {h, a} - b[5:0];
        f[FLAG_V] = ad ? !h[7] & w[15] : h[7] & !w[15];
        f[FLAG_C] = ad ? h[7] & !w[15] : w[15] & !h[7];
        f[FLAG_N] = w[15];
        f[FLAG_S] = w[15] ^ f[FLAG_V];
        f[FLAG_Z] = w == 16'h0000;
        return {w, f};
      end
      op_and, op_bitwise_and_with_constant: r = a & b;
      op_or, op_bitwise_or_with_constant, op_set_bits_by_mask: r = a | b;
      op_exclusive_or: r = a ^ b;
      op_clear_bits_by_mask: r = a & (8'hFF - b);
      op_bitwise_invert: begin
        r = 8'hFF - a;
        f[FLAG_C] = 1'b1;
      end
      default: begin
        if (op == op_arithmetic_minus) begin
          b = a;
          a = 8'h00;
        end
        s = {1'b0, a} - b - c;
        n = {1'b0, a[3:0]} - b[3:0] - c;
        r = s[7:0];
        f[FLAG_C] = s[8];
        f[FLAG_H] = n[4];
        f[FLAG_V] = a[7] != b[7] && r[7] != a[7];
      end
    endcase
    f[FLAG_Z] = r == 8'h00;
    f[FLAG_N] = r[7];
    return {h, r, f};
  endfunction
  task automatic do_op(input alu_op_t op, input logic [7:0] a, b, h);
    logic [21:0] e;
    logic wd;
    e = calc(op, a, b, h, exp_f);
    wd = op == op_word_add_immediate || op == op_word_subtract_immediate;
    op_valid = 1'b1;
    op_code = op;
    rd_val = a;
    rdh_val = h;
    rr_val = (op inside {op_add, op_add_carry, op_sub, op_and, op_or,
      op_exclusive_or, op_subtract_with_borrow}) ? b : ~b;
    imm = ~rr_val;
    @(negedge sys_clk);
    if (wd) begin
      `CHK(op_ready, 1'b0, "ready during word op")
      op_valid = 1'b0; // refused cycle: no request stands
      @(negedge sys_clk);
    end
    `CHK(res_valid, 1'b1, "no result")
    `CHK(res_pair, wd, "pair marker")
    `CHK({res_hi, res_lo}, e[21:6], "result")
    `CHK(flags, e[5:0], "flags")
    exp_f = e[5:0];
  endtask
  task automatic t_bytes;
    alu_op_t ops[18] = '{op_add, op_add, op_add_carry, op_subtract_constant,
      op_sub, op_subtract_with_borrow, op_subtract_constant_with_borrow,
      op_and, op_bitwise_and_with_constant, op_or,
      op_bitwise_or_with_constant, op_exclusive_or, op_bitwise_invert,
      op_arithmetic_minus, op_arithmetic_minus, op_set_bits_by_mask,
      op_clear_bits_by_mask, op_add_carry};
    logic [7:0] aa[18] = '{8'h0F, 8'h80, 8'h7F, 8'h80, 8'h00, 8'h10, 8'h00,
      8'hF0, 8'h3C, 8'h00, 8'h00, 8'h5A, 8'h55, 8'h80, 8'h00, 8'h10, 8'hFF,
      8'h01};
    logic [7:0] bb[18] = '{8'h01, 8'h80, 8'h00, 8'h01, 8'h01, 8'h0F, 8'h00,
      8'h0F, 8'hC3, 8'h00, 8'h01, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h81, 8'h0F,
      8'h01};
    // back to back so carry and borrow chain between operations
    for (int i = 0; i < 18; i++) begin
      do_op(ops[i], aa[i], bb[i], 8'h3C);
    end
  endtask
  task automatic t_words;
    do_op(op_word_add_immediate, 8'hFF, 8'hC1, 8'hFF);
    do_op(op_word_add_immediate, 8'hFF, 8'h3F, 8'h7F);
    do_op(op_word_subtract_immediate, 8'h00, 8'h01, 8'h00);
    do_op(op_word_subtract_immediate, 8'h00, 8'hC1, 8'h80);
  endtask
  task automatic t_bad;
    op_valid = 1'b1;
    op_code = 5'h1F;
    @(negedge sys_clk);
    op_valid = 1'b0;
    `CHK(bad_op, 1'b1, "unknown code not flagged")
    `CHK(res_valid, 1'b0, "unknown code gave result")
    `CHK(flags, exp_f, "unknown code changed flags")
  endtask
  task automatic io_req(input logic [1:0] c, input logic [5:0] ad,
      input logic [2:0] b, input logic [2:0] e);
    io_valid = 1'b1;
    io_cmd = c;
    io_addr = ad;
    io_bit = b;
    @(negedge sys_clk);
    `CHK({io_wr, io_skip, io_err}, e, "bit access outcome")
    if (e[2]) begin
      `CHK(io_wmask, 8'h01 << b, "bit mask")
      `CHK(io_wdata, c[0] ? 8'h00 : 8'h01 << b, "bit data")
    end
  endtask
  task automatic t_io;
    io_req(2'h0, 6'h1F, 3'd1, 3'b100);
    io_req(2'h0, 6'h1F, 3'd7, 3'b100);
    io_req(2'h1, 6'h1F, 3'd0, 3'b100);
    io_req(2'h2, 6'h1F, 3'd2, 3'b010);
    io_req(2'h3, 6'h1F, 3'd2, 3'b000);
    io_req(2'h3, 6'h1F, 3'd3, 3'b010);
    io_req(2'h0, 6'h20, 3'd4, 3'b001);
    io_req(2'h0, 6'h00, 3'd4, 3'b100);
    io_valid = 1'b0;
    @(negedge sys_clk);
    `CHK(i_io_reg_model.regs[31], 8'h26, "register after bits")
    `CHK(i_io_reg_model.regs[0], 8'hB5, "lowest register")
  endtask
  task automatic t_reset;
    srst = 1'b1;
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    `CHK({op_ready, res_valid, res_pair, flags}, 9'h100, "reset state")
    exp_f = 6'h00;
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // clock and run-length guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    {op_valid, io_valid, op_code, io_cmd, io_addr, io_bit} = '0;
    {rd_val, rdh_val, rr_val, imm} = '0;
    t_reset();
    @(negedge sys_clk);
    t_bytes();
    t_words();
    t_bad();
    t_io();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
